// File: hw/dscs_pkg.sv
// What the document requires of this block and of the bus
// RQ1: slave address holds 00 to FF, resets to 1F, takes effect after restart.
// RQ2: the network master gives every slave on the bus its own address.
// RQ3: baud codes 0 to 8 select 1200 up to 115200 bps, effective after restart.
// RQ4: protocol 1 with any baud code except 9600 raises the configuration error.
// RQ5: protocol 2 with any baud code except 4800 raises the configuration error.
// RQ6: baud code 8 raises the error under protocols 0, 1 and 3.
// RQ7: unwritten baud code defaults to 3, or to 2 under protocol 2.
// RQ8: parity 0 none, 1 even, 2 odd; default 0; effective after restart.
// RQ9: loss action 0 ramp, 1 coast, 2 fast, 3 alarm only, 4 preset speed.
// RQ10: ramp stop uses the deceleration time active at that moment.
// RQ11: loss detection enable defaults to 1; at 0 no loss is detected.
// RQ12: silence longer than the detection time raises loss fault and its action.
// RQ13: detection time 0.0 to 10.0 s in tenths, default 2.0 s.
// RQ14: response starts only after the transmit wait time following a request.
// RQ15: driver enable always on at control 0, only while sending at 1.
// RQ16: protocol code 0 to 3 selects the active protocol, default 0.
// RQ17: apply-on-enter 0 holds written values until an enter command arrives.
// RQ18: apply-on-enter 1 makes written values effective at once.
// RQ19: run method 0: bit 0 forward run, bit 1 reverse run.
// RQ20: run method 1: bit 0 run, bit 1 direction.
// RQ21: instance id is low word plus 6-bit high word, ignored under protocol 1.
// RQ22: every received frame restarts the loss detection timer.
package dscs_pkg;

	localparam int CLK_MHZ = 100;
	localparam int CLK_HZ = CLK_MHZ * 1000000;
	localparam int TICK_TIME_US = 1000;
	localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
	localparam int MS_PER_TENTH = 100;

	localparam logic [7:0] OFS_SLAVE_ADDR = 8'h00;
	localparam logic [7:0] OFS_BAUD_CODE = 8'h04;
	localparam logic [7:0] OFS_PARITY = 8'h08;
	localparam logic [7:0] OFS_LOSS_ACTION = 8'h0C;
	localparam logic [7:0] OFS_LOSS_EN = 8'h10;
	localparam logic [7:0] OFS_TX_WAIT = 8'h14;
	localparam logic [7:0] OFS_DE_CTRL = 8'h18;
	localparam logic [7:0] OFS_PROTOCOL = 8'h1C;
	localparam logic [7:0] OFS_LOSS_TIME = 8'h20;
	localparam logic [7:0] OFS_APPLY_NOW = 8'h24;
	localparam logic [7:0] OFS_RUN_METHOD = 8'h28;
	localparam logic [7:0] OFS_ID_LOW = 8'h2C;
	localparam logic [7:0] OFS_ID_HIGH = 8'h30;
	localparam logic [7:0] OFS_ENTER = 8'h34;
	localparam logic [7:0] OFS_RESTART = 8'h38;
	localparam logic [7:0] OFS_STATUS = 8'h3C;
	localparam logic [7:0] OFS_CMD_WORD = 8'h40;

	localparam logic [7:0] RST_SLAVE_ADDR = 8'h1F;
	localparam logic [3:0] BAUD_4800 = 4'h2;
	localparam logic [3:0] BAUD_9600 = 4'h3;
	localparam logic [3:0] BAUD_MAX = 4'h8;
	localparam logic [1:0] RST_PARITY = 2'h0;
	localparam logic [2:0] RST_LOSS_ACTION = 3'h3;
	localparam logic RST_LOSS_EN = 1'b1;
	localparam logic [7:0] RST_TX_WAIT = 8'h0A;
	localparam logic RST_DE_CTRL = 1'b1;
	localparam logic [1:0] RST_PROTOCOL = 2'h0;
	localparam logic [6:0] RST_LOSS_TIME = 7'h14;
	localparam logic [6:0] MAX_LOSS_TIME = 7'h64;
	localparam logic RST_APPLY_NOW = 1'b0;
	localparam logic RST_RUN_METHOD = 1'b0;
	localparam logic [15:0] RST_ID_LOW = 16'h0001;
	localparam logic [5:0] RST_ID_HIGH = 6'h00;

	localparam logic [1:0] PROTO_SECOND = 2'h1;
	localparam logic [1:0] PROTO_THIRD = 2'h2;

	typedef enum logic [2:0] {
		LOSS_RAMP,
		LOSS_COAST,
		LOSS_FAST,
		LOSS_ALARM,
		LOSS_PRESET
	} dscs_loss_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [3:0] baud;
		logic baud_set;
		logic [1:0] parity;
		logic [2:0] loss_action;
		logic loss_en;
		logic [7:0] tx_wait;
		logic de_ctrl;
		logic [1:0] protocol;
		logic [6:0] loss_time;
		logic apply_now;
		logic run_method;
		logic [15:0] id_lo;
		logic [5:0] id_hi;
	} dscs_cfg_s;

	localparam dscs_cfg_s RST_CFG = '{RST_SLAVE_ADDR, BAUD_9600, 1'b0, RST_PARITY, RST_LOSS_ACTION,
		RST_LOSS_EN, RST_TX_WAIT, RST_DE_CTRL, RST_PROTOCOL, RST_LOSS_TIME, RST_APPLY_NOW,
		RST_RUN_METHOD, RST_ID_LOW, RST_ID_HIGH};

	typedef struct packed {
		logic ramp;
		logic coast;
		logic fast;
		logic alarm;
		logic preset;
	} dscs_loss_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [3:0] baud;
		logic [16:0] baud_div;
		logic [1:0] parity;
		logic [1:0] protocol;
		logic [21:0] instance_id;
		logic cfg_err;
	} dscs_link_s;

	typedef struct packed {
		logic run_fwd;
		logic run_rev;
	} dscs_run_s;

endpackage : dscs_pkg

// File: hw/dscs_top.sv
`timescale 1ns/100ps
`default_nettype none
module dscs_top #(
	parameter int TICK_CYCLES_P = dscs_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// serial engine events
	input wire logic frame_rx_i,
	input wire logic tx_busy_i,
	output logic tx_start_o,
	output logic driver_enable_o,
	// line settings in force
	output dscs_pkg::dscs_link_s link_o,
	// drive control
	output dscs_pkg::dscs_loss_s loss_o,
	output logic loss_fault_o,
	output dscs_pkg::dscs_run_s run_o
);
	import dscs_pkg::*;

	initial
	begin
		if (TICK_CYCLES_P < 1 || TICK_CYCLES_P > 131071)
			$error("tick count out of range");
	end

	typedef struct packed {
		dscs_cfg_s staged;
		dscs_cfg_s stored;
		logic [7:0] act_addr;
		logic [3:0] act_baud;
		logic [1:0] act_parity;
		logic [1:0] cmd_bits;
		logic [16:0] div_cnt;
		logic [13:0] loss_ms;
		logic loss_fault;
		logic tx_pend;
		logic [8:0] wait_ms;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic tx_start;
		logic de;
		dscs_link_s link;
		dscs_loss_s loss;
		dscs_run_s run;
	} dscs_state_s;

	dscs_state_s st_q;
	dscs_state_s st_d;

	function automatic logic [16:0] dscs_baud_div(input logic [3:0] code);
		int bps;
		case (code)
			4'h0: bps = 1200;
			4'h1: bps = 2400;
			4'h2: bps = 4800;
			4'h3: bps = 9600;
			4'h4: bps = 19200;
			4'h5: bps = 38400;
			4'h6: bps = 57600;
			4'h7: bps = 76800;
			default: bps = 115200;
		endcase
		return 17'(CLK_HZ / bps); // [RQ3]
	endfunction : dscs_baud_div

	// an unwritten baud code follows the protocol's default
	function automatic logic [3:0] dscs_eff_baud(input dscs_cfg_s c);
		if (c.baud_set)
			return c.baud;
		return (c.protocol == PROTO_THIRD) ? BAUD_4800 : BAUD_9600; // [RQ7]
	endfunction : dscs_eff_baud

	function automatic logic dscs_speed_err(input logic [1:0] proto, input logic [3:0] b);
		logic e;
		e = (b > BAUD_MAX);
		if (proto == PROTO_SECOND && b != BAUD_9600)
			e = 1'b1; // [RQ4]
		if (proto == PROTO_THIRD && b != BAUD_4800)
			e = 1'b1; // [RQ5]
		if (proto != PROTO_THIRD && b == BAUD_MAX)
			e = 1'b1; // [RQ6]
		return e;
	endfunction : dscs_speed_err

	function automatic dscs_cfg_s dscs_write(input dscs_cfg_s c, input logic [7:0] a, input logic [31:0] w);
		dscs_cfg_s r;
		r = c;
		unique case (a)
			OFS_SLAVE_ADDR: r.addr = w[7:0]; // [RQ1]
			OFS_BAUD_CODE:
			begin
				r.baud = w[3:0];
				r.baud_set = 1'b1;
			end
			OFS_PARITY: r.parity = (w[1:0] == 2'h3) ? c.parity : w[1:0]; // [RQ8]
			OFS_LOSS_ACTION: r.loss_action = (w[2:0] > 3'(LOSS_PRESET)) ? c.loss_action : w[2:0]; // [RQ9]
			OFS_LOSS_EN: r.loss_en = w[0]; // [RQ11]
			OFS_TX_WAIT: r.tx_wait = w[7:0];
			OFS_DE_CTRL: r.de_ctrl = w[0];
			OFS_PROTOCOL: r.protocol = w[1:0]; // [RQ16]
			OFS_LOSS_TIME: r.loss_time = (w[6:0] > MAX_LOSS_TIME) ? c.loss_time : w[6:0]; // [RQ13]
			OFS_APPLY_NOW: r.apply_now = w[0];
			OFS_RUN_METHOD: r.run_method = w[0];
			OFS_ID_LOW: r.id_lo = w[15:0];
			OFS_ID_HIGH: r.id_hi = w[5:0]; // [RQ21]
			default: r = c;
		endcase
		return r;
	endfunction : dscs_write

	function automatic logic dscs_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= OFS_CMD_WORD);
	endfunction : dscs_mapped

	always_comb
	begin
		dscs_state_s n;
		dscs_cfg_s c;
		logic wr;
		logic rd_setup;
		logic tick;
		logic [3:0] eff_baud;
		logic [13:0] limit_ms;
		n = st_q;
		c = st_q.stored;
		wr = psel_i && penable_i && st_q.pready && pwrite_i && dscs_mapped(paddr_i);
		rd_setup = psel_i && !penable_i;
		tick = (st_q.div_cnt == 17'(TICK_CYCLES_P - 1));
		eff_baud = dscs_eff_baud(c);
		limit_ms = 14'(c.loss_time) * 14'(MS_PER_TENTH);

		// no wait state: the answer is built in setup and shown in the first access cycle
		n.pready = rd_setup;
		n.pslverr = rd_setup && !dscs_mapped(paddr_i);
		n.prdata = 32'h0000_0000;
		if (rd_setup && !pwrite_i)
		begin
			unique case (paddr_i)
				OFS_SLAVE_ADDR: n.prdata = {24'h00_0000, st_q.staged.addr};
				OFS_BAUD_CODE: n.prdata = {28'h000_0000, dscs_eff_baud(st_q.staged)};
				OFS_PARITY: n.prdata = {30'h0000_0000, st_q.staged.parity};
				OFS_LOSS_ACTION: n.prdata = {29'h0000_0000, st_q.staged.loss_action};
				OFS_LOSS_EN: n.prdata = {31'h0000_0000, st_q.staged.loss_en};
				OFS_TX_WAIT: n.prdata = {24'h00_0000, st_q.staged.tx_wait};
				OFS_DE_CTRL: n.prdata = {31'h0000_0000, st_q.staged.de_ctrl};
				OFS_PROTOCOL: n.prdata = {30'h0000_0000, st_q.staged.protocol};
				OFS_LOSS_TIME: n.prdata = {25'h000_0000, st_q.staged.loss_time};
				OFS_APPLY_NOW: n.prdata = {31'h0000_0000, st_q.staged.apply_now};
				OFS_RUN_METHOD: n.prdata = {31'h0000_0000, st_q.staged.run_method};
				OFS_ID_LOW: n.prdata = {16'h0000, st_q.staged.id_lo};
				OFS_ID_HIGH: n.prdata = {26'h000_0000, st_q.staged.id_hi};
				OFS_STATUS: n.prdata = {10'h000, st_q.act_parity, st_q.act_baud, st_q.act_addr,
					4'h0, st_q.tx_pend, st_q.de, st_q.loss_fault, st_q.link.cfg_err};
				OFS_CMD_WORD: n.prdata = {30'h0000_0000, st_q.cmd_bits};
				default: n.prdata = 32'h0000_0000;
			endcase
		end

		// writes land in the staged copy; the stored copy steers the block
		if (wr)
		begin
			n.staged = dscs_write(st_q.staged, paddr_i, pwdata_i);
			if (c.apply_now)
				n.stored = dscs_write(c, paddr_i, pwdata_i); // [RQ18]
			if (paddr_i == OFS_ENTER)
				n.stored = st_q.staged; // [RQ17]
			if (paddr_i == OFS_CMD_WORD)
				n.cmd_bits = pwdata_i[1:0];
			// restart stands in for a power cycle of the line settings
			if (paddr_i == OFS_RESTART)
			begin
				n.act_addr = c.addr; // [RQ1]
				n.act_baud = eff_baud; // [RQ3]
				n.act_parity = c.parity; // [RQ8]
			end
		end

		n.div_cnt = tick ? 17'h0_0000 : st_q.div_cnt + 17'h0_0001;

		// loss timer restarts on every frame so only steady silence counts
		if (frame_rx_i || !c.loss_en)
		begin
			n.loss_ms = 14'h0000; // [RQ22]
			n.loss_fault = 1'b0; // [RQ11]
		end
		else
		begin
			if (tick && st_q.loss_ms != 14'h3FFF)
				n.loss_ms = st_q.loss_ms + 14'h0001;
			if (st_q.loss_ms > limit_ms)
				n.loss_fault = 1'b1; // [RQ12]
		end

		// the first tick after a frame is partial, so one extra tick is counted:
		// the wait never falls short, and may run up to one tick long
		n.tx_start = 1'b0;
		if (frame_rx_i)
		begin
			n.tx_pend = 1'b1;
			n.wait_ms = 9'h000;
		end
		else if (st_q.tx_pend)
		begin
			if (st_q.wait_ms > {1'b0, c.tx_wait})
			begin
				n.tx_pend = 1'b0;
				n.tx_start = 1'b1; // [RQ14]
			end
			else if (tick)
				n.wait_ms = st_q.wait_ms + 9'h001;
		end

		n.de = !c.de_ctrl || tx_busy_i; // [RQ15]

		n.link.addr = st_q.act_addr;
		n.link.baud = st_q.act_baud;
		n.link.baud_div = dscs_baud_div(st_q.act_baud); // [RQ3]
		n.link.parity = st_q.act_parity; // [RQ8]
		n.link.protocol = c.protocol; // [RQ16]
		n.link.instance_id = (c.protocol == PROTO_SECOND) ? 22'h00_0000 : {c.id_hi, c.id_lo}; // [RQ21]
		n.link.cfg_err = dscs_speed_err(c.protocol, eff_baud);

		n.loss = '0;
		if (st_q.loss_fault)
		begin
			unique case (dscs_loss_e'(c.loss_action))
				LOSS_RAMP: n.loss.ramp = 1'b1; // [RQ10]
				LOSS_COAST: n.loss.coast = 1'b1;
				LOSS_FAST: n.loss.fast = 1'b1;
				LOSS_ALARM: n.loss.alarm = 1'b1;
				LOSS_PRESET: n.loss.preset = 1'b1; // [RQ9]
				default: n.loss.alarm = 1'b1;
			endcase
		end

		if (c.run_method)
		begin
			n.run.run_fwd = st_q.cmd_bits[0] && !st_q.cmd_bits[1]; // [RQ20]
			n.run.run_rev = st_q.cmd_bits[0] && st_q.cmd_bits[1];
		end
		else
		begin
			n.run.run_fwd = st_q.cmd_bits[0]; // [RQ19]
			n.run.run_rev = st_q.cmd_bits[1];
		end
		st_d = n;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			st_q <= '0;
			st_q.staged <= RST_CFG;
			st_q.stored <= RST_CFG;
			st_q.act_addr <= RST_SLAVE_ADDR;
			st_q.act_baud <= BAUD_9600;
			st_q.act_parity <= RST_PARITY;
			st_q.de <= 1'b0;
			st_q.link.addr <= RST_SLAVE_ADDR;
			st_q.link.baud <= BAUD_9600;
		end
		else
			st_q <= st_d;
	end

	assign prdata_o = st_q.prdata;
	assign pready_o = st_q.pready;
	assign pslverr_o = st_q.pslverr;
	assign tx_start_o = st_q.tx_start;
	assign driver_enable_o = st_q.de;
	assign link_o = st_q.link;
	assign loss_o = st_q.loss;
	assign loss_fault_o = st_q.loss_fault;
	assign run_o = st_q.run;

endmodule : dscs_top
`default_nettype wire

// File: test/dscs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module dscs_sva
	import dscs_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// serial engine
	input wire logic frame_rx_i,
	input wire logic tx_busy_i,
	input wire logic tx_start_o,
	input wire logic driver_enable_o,
	// settings and drive control
	input wire dscs_link_s link_o,
	input wire dscs_loss_s loss_o,
	input wire logic loss_fault_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	setup_answer_a: assert property (psel_i && !penable_i |=> pready_o) else $error("no access answer");
	ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready held");
	err_zero_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("bad error read");
	loss_hot_a: assert property (loss_fault_o |=> $onehot(loss_o)) else $error("loss action not one-hot");
	frame_clear_a: assert property (frame_rx_i |=> !loss_fault_o) else $error("fault after frame");
	fault_quiet_a: assert property ($rose(loss_fault_o) |-> !$past(frame_rx_i)) else $error("fault too early");
	de_busy_a: assert property (tx_busy_i |=> driver_enable_o) else $error("driver off while sending");
	start_pulse_a: assert property (tx_start_o |=> !tx_start_o) else $error("start not a pulse");
	start_wait_a: assert property (frame_rx_i |=> !tx_start_o) else $error("response without wait");
	id_ignore_a: assert property (link_o.protocol == PROTO_SECOND |-> link_o.instance_id == 22'h0)
		else $error("id not ignored");

	cover property (loss_fault_o);
	cover property (tx_start_o);
	cover property (pready_o && pslverr_o);
endmodule : dscs_sva
`default_nettype wire

// File: test/dscs_ser_model.sv
`timescale 1ns/100ps
`default_nettype none
module dscs_ser_model #(
	parameter int BUSY_P = 12
) (
	input wire logic clk_sys_i,
	input wire logic tx_start_i,
	output logic frame_rx_o,
	output logic tx_busy_o
);
	int n = 0;
	initial
	begin
		frame_rx_o = 1'b0;
		tx_busy_o = 1'b0;
	end
	// only this slave is addressed, so no two slaves share an address
	task frame();
		@(posedge clk_sys_i);
		frame_rx_o <= 1'b1;
		@(posedge clk_sys_i);
		frame_rx_o <= 1'b0;
	endtask : frame
	// a fixed send time keeps driver-enable checks predictable
	always @(posedge clk_sys_i)
	begin
		if (tx_start_i)
			n <= BUSY_P;
		else if (n > 0)
			n <= n - 1;
		tx_busy_o <= tx_start_i || n > 1;
	end
endmodule : dscs_ser_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("BAD %0t %0h %0h", $time, g, e); end end
module tb_top
	import dscs_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic frame_rx;
	logic tx_busy;
	logic tx_start_o;
	logic driver_enable_o;
	dscs_link_s link_o;
	dscs_loss_s loss_o;
	logic loss_fault_o;
	dscs_run_s run_o;
	logic [31:0] rdat;
	logic rerr;
	int compares = 0;
	int failures = 0;
	int cyc_n = 0;
	int i, j, k, b;
	logic [15:0] rv [13] = '{16'h1F, 16'h3, 16'h0, 16'h3, 16'h1, 16'h0A, 16'h1, 16'h0, 16'h14, 16'h0, 16'h0, 16'h1, 16'h0};
	int bps [9] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200};
	logic [3:0] bc [3] = '{4'h2, 4'h3, 4'h8};

	always #5 clk_sys_i = ~clk_sys_i;

	dscs_top #(.TICK_CYCLES_P(10)) dscs_top_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .frame_rx_i(frame_rx), .tx_busy_i(tx_busy),
		.tx_start_o(tx_start_o), .driver_enable_o(driver_enable_o), .link_o(link_o), .loss_o(loss_o),
		.loss_fault_o(loss_fault_o), .run_o(run_o));
	dscs_ser_model dscs_ser_model_i (.clk_sys_i(clk_sys_i), .tx_start_i(tx_start_o), .frame_rx_o(frame_rx),
		.tx_busy_o(tx_busy));

	task give_verdict();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	// entered just after a rising edge; request held until pready is sampled
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		n = 0;
		do @(posedge clk_sys_i) n++; while (pready_o !== 1'b1 && n < 50);
		rdat = prdata_o;
		rerr = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask : rc

	task cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : cyc

	always @(posedge clk_sys_i)
	begin
		cyc_n++;
		if (cyc_n == 40000)
		begin
			failures++;
			give_verdict();
		end
	end

	initial
	begin
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		for (i = 0; i < 13; i++)
			rc(8'(i * 4), 32'(rv[i]));
		rc(8'h44, 32'h0);
		`CHK(rerr, 1'b1)
		wr(8'h1C, 32'h2);
		wr(8'h34, 32'h0);
		rc(8'h04, 32'h2);
		wr(8'h00, 32'h55);
		wr(8'h38, 32'h0);
		cyc(3);
		`CHK(link_o.addr, 8'h1F)
		wr(8'h34, 32'h0);
		wr(8'h38, 32'h0);
		cyc(3);
		`CHK(link_o.addr, 8'h55)
		for (i = 0; i < 4; i++)
			for (j = 0; j < 3; j++)
			begin
				b = bc[j];
				wr(8'h1C, 32'(i));
				wr(8'h04, 32'(b));
				wr(8'h34, 32'h0);
				cyc(3);
				apb(1'b0, 8'h3C, 32'h0);
				`CHK(rdat[0], (i == 1) ? b != 3 : (i == 2) ? b != 2 : b == 8)
			end
		for (i = 0; i < 9; i++)
		begin
			wr(8'h04, 32'(i));
			wr(8'h34, 32'h0);
			wr(8'h38, 32'h0);
			cyc(3);
			`CHK(link_o.baud_div, 17'(100000000 / bps[i]))
		end
		`CHK(link_o.instance_id, 22'h00_0001)
		wr(8'h08, 32'h2);
		wr(8'h34, 32'h0);
		wr(8'h38, 32'h0);
		cyc(3);
		`CHK(link_o.parity, 2'h2)
		wr(8'h24, 32'h1);
		wr(8'h34, 32'h0);
		for (i = 0; i < 2; i++)
			for (j = 0; j < 4; j++)
			begin
				wr(8'h28, 32'(i));
				wr(8'h40, 32'(j));
				cyc(3);
				`CHK(run_o, (i == 1) ? {j == 1, j == 3} : {j % 2 == 1, j >= 2})
			end
		wr(8'h20, 32'h1);
		wr(8'h20, 32'h65);
		rc(8'h20, 32'h1);
		for (i = 0; i < 5; i++)
		begin
			wr(8'h0C, 32'(i));
			dscs_ser_model_i.frame();
			cyc(900);
			dscs_ser_model_i.frame();
			cyc(300);
			`CHK(loss_fault_o, 1'b0)
			cyc(900);
			`CHK(loss_o, 5'h10 >> i)
		end
		wr(8'h10, 32'h0);
		cyc(1500);
		`CHK(loss_fault_o, 1'b0)
		wr(8'h14, 32'h3);
		dscs_ser_model_i.frame();
		k = 0;
		while (tx_start_o !== 1'b1 && k < 100)
		begin
			@(posedge clk_sys_i);
			k++;
		end
		`CHK(k >= 30 && k <= 42, 1'b1)
		cyc(2);
		`CHK(driver_enable_o, 1'b1)
		cyc(20);
		`CHK(driver_enable_o, 1'b0)
		wr(8'h18, 32'h0);
		cyc(3);
		`CHK(driver_enable_o, 1'b1)
		give_verdict();
	end
endmodule : tb_top

bind dscs_top dscs_sva dscs_sva_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.frame_rx_i(frame_rx_i), .tx_busy_i(tx_busy_i), .tx_start_o(tx_start_o),
	.driver_enable_o(driver_enable_o), .link_o(link_o), .loss_o(loss_o), .loss_fault_o(loss_fault_o));
`default_nettype wire
